// *** design/amd_regs.svh ***
`ifndef AMD_REGS_SVH
`define AMD_REGS_SVH

// Opcode page, direct page and zero constants.
`define AMD_PAGE2_PREFIX 8'h18
`define AMD_DIRECT_PAGE_HI 8'h00
`define AMD_ZERO8 8'h00
`define AMD_ZERO16 16'h0000

// Index postbyte fields.
`define AMD_XB_SHORT_RR 7:6
`define AMD_XB_LONG_RR 4:3
`define AMD_XB_LONG_TAG 7:5
`define AMD_XB_FORM 5
`define AMD_XB_OFF5 4:0
`define AMD_XB_OFF5_SIGN 4
`define AMD_XB_ACC_BIT 2
`define AMD_XB_ZS 1:0
`define AMD_XB_Z 1
`define AMD_XB_S 0
`define AMD_XB_P 4
`define AMD_XB_AUTO_N 3:0
`define AMD_XB_AUTO_SIGN 3

// Postbyte field values.
`define AMD_LONG_TAG 3'h7
`define AMD_ZS_INDIRECT 2'h3
`define AMD_ACC_A 2'h0
`define AMD_ACC_B 2'h1
`define AMD_ACC_D 2'h2
`define AMD_BASE_X 2'h0
`define AMD_BASE_Y 2'h1
`define AMD_BASE_SP 2'h2
`define AMD_BASE_PC 2'h3

// Extension byte counts and the auto-step increment.
`define AMD_EXT_NONE 2'h0
`define AMD_EXT_ONE 2'h1
`define AMD_EXT_TWO 2'h2
`define AMD_AUTO_STEP 4'h1

`endif

// *** design/amd_pkg.sv ***
package amd_pkg;

    typedef enum logic [3:0] {
        AMD_NO_OPERAND_MODE = 4'h0,
        AMD_LITERAL_OPERAND_MODE_B = 4'h1,
        AMD_LITERAL_OPERAND_MODE_W = 4'h2,
        AMD_DIRECT_PAGE_MODE = 4'h3,
        AMD_FULL_ADDRESS_MODE = 4'h4,
        AMD_RELATIVE_MODE_B = 4'h5,
        AMD_RELATIVE_MODE_W = 4'h6,
        AMD_INDEXED_MODE = 4'h7,
        AMD_POSTBYTE_ONLY_MODE = 4'h8
    } amd_mode_t;

    typedef enum logic [2:0] {
        AMD_SHORT_INDEXED_MODE = 3'b000,
        AMD_AUTO_STEP_MODE = 3'b001,
        AMD_ACC_OFFSET_MODE = 3'b010,
        AMD_NINE_BIT_INDEXED_MODE = 3'b011,
        AMD_SIXTEEN_BIT_INDEXED_MODE = 3'b100,
        AMD_OFFSET_INDIRECT_MODE = 3'b101,
        AMD_DOUBLE_ACC_INDIRECT_MODE = 3'b110
    } amd_idx_t;

    typedef enum logic [2:0] {
        AMD_S_OPCODE = 3'b000,
        AMD_S_POSTBYTE = 3'b001,
        AMD_S_EXTENSION = 3'b010,
        AMD_S_PTR_HI = 3'b011,
        AMD_S_PTR_LO = 3'b100,
        AMD_S_DONE = 3'b101
    } amd_state_t;

endpackage

// *** design/amd_xb_decode.sv ***
`timescale 1ns/10ps
`include "amd_regs.svh"

module amd_xb_decode
    import amd_pkg::*;
(
    // Index postbyte.
    input wire logic [7:0] i_xb,
    // Decoded fields.
    output amd_idx_t o_kind,
    output logic [1:0] o_base_sel,
    output logic [1:0] o_ext_cnt,
    output logic [15:0] o_const_off,
    output logic o_post_update,
    output logic [1:0] o_acc_sel
);

    always_comb begin
        o_kind = AMD_SHORT_INDEXED_MODE;
        o_base_sel = i_xb[`AMD_XB_SHORT_RR];
        o_ext_cnt = `AMD_EXT_NONE;
        o_const_off = {{11{i_xb[`AMD_XB_OFF5_SIGN]}}, i_xb[`AMD_XB_OFF5]};
        o_post_update = 1'h0;
        o_acc_sel = i_xb[`AMD_XB_ZS];
        if (i_xb[`AMD_XB_LONG_TAG] == `AMD_LONG_TAG) begin
            o_base_sel = i_xb[`AMD_XB_LONG_RR];
            if (!i_xb[`AMD_XB_ACC_BIT]) begin
                if (i_xb[`AMD_XB_ZS] == `AMD_ZS_INDIRECT) begin
                    o_kind = AMD_OFFSET_INDIRECT_MODE;
                    o_ext_cnt = `AMD_EXT_TWO;
                end else if (i_xb[`AMD_XB_Z]) begin
                    o_kind = AMD_SIXTEEN_BIT_INDEXED_MODE;
                    o_ext_cnt = `AMD_EXT_TWO;
                end else begin
                    o_kind = AMD_NINE_BIT_INDEXED_MODE;
                    o_ext_cnt = `AMD_EXT_ONE;
                end
            end else if (i_xb[`AMD_XB_ZS] == `AMD_ZS_INDIRECT) begin
                o_kind = AMD_DOUBLE_ACC_INDIRECT_MODE;
            end else begin
                o_kind = AMD_ACC_OFFSET_MODE;
            end
        end else if (i_xb[`AMD_XB_FORM]) begin
            // The long-form tag claims rr=11 here, so PC never reaches this branch.
            o_kind = AMD_AUTO_STEP_MODE;
            o_post_update = i_xb[`AMD_XB_P];
            if (i_xb[`AMD_XB_AUTO_SIGN]) begin
                o_const_off = {{12{1'h1}}, i_xb[`AMD_XB_AUTO_N]};
            end else begin
                o_const_off = {12'h000, i_xb[`AMD_XB_AUTO_N] + `AMD_AUTO_STEP};
            end
        end
    end

endmodule

// *** design/amd_decoder.sv ***
`timescale 1ns/10ps
`include "amd_regs.svh"


module amd_decoder
    import amd_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Instruction queue.
    input wire logic i_q_valid,
    input wire logic [7:0] i_q_byte,
    input wire amd_mode_t i_q_mode,
    output logic o_q_ready,
    // Core registers.
    input wire logic [ADDR_W-1:0] i_reg_x,
    input wire logic [ADDR_W-1:0] i_reg_y,
    input wire logic [ADDR_W-1:0] i_reg_sp,
    input wire logic [ADDR_W-1:0] i_reg_pc,
    input wire logic [7:0] i_acc_a,
    input wire logic [7:0] i_acc_b,
    // Pointer fetch.
    output logic o_mem_req,
    output logic [ADDR_W-1:0] o_mem_addr,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_data,
    // Decode result.
    output logic o_done,
    output logic o_page2,
    output logic [7:0] o_opcode,
    output amd_mode_t o_mode,
    output logic [7:0] o_postbyte,
    output amd_idx_t o_idx_kind,
    output logic [ADDR_W-1:0] o_ea,
    output logic [ADDR_W-1:0] o_operand,
    output logic o_upd_en,
    output logic [1:0] o_upd_sel,
    output logic [ADDR_W-1:0] o_upd_val
);

    if (ADDR_W != 16) begin : g_width_check
        $error("amd_decoder serves a sixteen-bit address space only");
    end

    amd_state_t state_r;
    amd_state_t state_nxt;
    amd_mode_t mode_r;
    logic page2_r;
    logic [7:0] opc_r;
    logic [7:0] post_r;
    logic [15:0] ext_r;
    logic [1:0] ext_left_r;
    logic [15:0] ptr_r;
    logic take;
    logic [7:0] xb_in;
    amd_idx_t kind;
    logic [1:0] base_sel;
    logic [1:0] xb_ext_cnt;
    logic [15:0] const_off;
    logic post_update;
    logic [1:0] acc_sel;
    logic [15:0] base_val;
    logic [15:0] acc_off;
    logic [15:0] idx_off;
    logic [15:0] idx_sum;
    logic [15:0] ea_calc;
    logic is_indirect;

    function automatic logic [15:0] sext8(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction

    function automatic logic [1:0] mode_ext_cnt(input amd_mode_t m);
        case (m)
            AMD_LITERAL_OPERAND_MODE_B, AMD_DIRECT_PAGE_MODE,
            AMD_RELATIVE_MODE_B: return `AMD_EXT_ONE;
            AMD_LITERAL_OPERAND_MODE_W, AMD_FULL_ADDRESS_MODE,
            AMD_RELATIVE_MODE_W: return `AMD_EXT_TWO;
            default: return `AMD_EXT_NONE;
        endcase
    endfunction

    function automatic logic consumes(input amd_state_t s);
        return (s == AMD_S_OPCODE) || (s == AMD_S_POSTBYTE) || (s == AMD_S_EXTENSION);
    endfunction

    assign take = o_q_ready & i_q_valid;
    // The postbyte is decoded live while it is taken, and from its register afterwards.
    assign xb_in = (state_r == AMD_S_POSTBYTE) ? i_q_byte : post_r;
    assign is_indirect = (kind == AMD_OFFSET_INDIRECT_MODE)
        || (kind == AMD_DOUBLE_ACC_INDIRECT_MODE);

    amd_xb_decode u_xb_decode (
        .i_xb(xb_in),
        .o_kind(kind),
        .o_base_sel(base_sel),
        .o_ext_cnt(xb_ext_cnt),
        .o_const_off(const_off),
        .o_post_update(post_update),
        .o_acc_sel(acc_sel)
    );

    always_comb begin
        case (base_sel)
            `AMD_BASE_X: base_val = i_reg_x;
            `AMD_BASE_Y: base_val = i_reg_y;
            `AMD_BASE_SP: base_val = i_reg_sp;
            default: base_val = i_reg_pc;
        endcase
        case (acc_sel)
            `AMD_ACC_A: acc_off = {`AMD_ZERO8, i_acc_a};
            `AMD_ACC_B: acc_off = {`AMD_ZERO8, i_acc_b};
            default: acc_off = {i_acc_a, i_acc_b};
        endcase
        case (kind)
            AMD_NINE_BIT_INDEXED_MODE: idx_off = {{8{post_r[`AMD_XB_S]}}, ext_r[7:0]};
            AMD_SIXTEEN_BIT_INDEXED_MODE, AMD_OFFSET_INDIRECT_MODE: idx_off = ext_r;
            AMD_ACC_OFFSET_MODE, AMD_DOUBLE_ACC_INDIRECT_MODE: idx_off = acc_off;
            default: idx_off = const_off;
        endcase
        idx_sum = base_val + idx_off;
    end

    always_comb begin
        case (mode_r)
            AMD_DIRECT_PAGE_MODE: ea_calc = {`AMD_DIRECT_PAGE_HI, ext_r[7:0]};
            AMD_FULL_ADDRESS_MODE: ea_calc = ext_r;
            AMD_RELATIVE_MODE_B: ea_calc = i_reg_pc + sext8(ext_r[7:0]);
            AMD_RELATIVE_MODE_W: ea_calc = i_reg_pc + ext_r;
            AMD_INDEXED_MODE: begin
                if (is_indirect) begin
                    ea_calc = ptr_r;
                end else if (kind == AMD_AUTO_STEP_MODE && post_update) begin
                    ea_calc = base_val;
                end else begin
                    ea_calc = idx_sum;
                end
            end
            default: ea_calc = `AMD_ZERO16;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AMD_S_OPCODE: begin
                if (take && !(i_q_byte == `AMD_PAGE2_PREFIX && !page2_r)) begin
                    case (i_q_mode)
                        AMD_NO_OPERAND_MODE: state_nxt = AMD_S_DONE;
                        AMD_INDEXED_MODE, AMD_POSTBYTE_ONLY_MODE: state_nxt = AMD_S_POSTBYTE;
                        default: state_nxt = AMD_S_EXTENSION;
                    endcase
                end
            end
            AMD_S_POSTBYTE: begin
                if (take) begin
                    if (mode_r == AMD_POSTBYTE_ONLY_MODE) begin
                        state_nxt = AMD_S_DONE;
                    end else if (xb_ext_cnt != `AMD_EXT_NONE) begin
                        state_nxt = AMD_S_EXTENSION;
                    end else if (kind == AMD_DOUBLE_ACC_INDIRECT_MODE) begin
                        state_nxt = AMD_S_PTR_HI;
                    end else begin
                        state_nxt = AMD_S_DONE;
                    end
                end
            end
            AMD_S_EXTENSION: begin
                if (take && ext_left_r == `AMD_EXT_ONE) begin
                    if (mode_r == AMD_INDEXED_MODE && kind == AMD_OFFSET_INDIRECT_MODE) begin
                        state_nxt = AMD_S_PTR_HI;
                    end else begin
                        state_nxt = AMD_S_DONE;
                    end
                end
            end
            AMD_S_PTR_HI: begin
                if (i_mem_ack) begin
                    state_nxt = AMD_S_PTR_LO;
                end
            end
            AMD_S_PTR_LO: begin
                if (i_mem_ack) begin
                    state_nxt = AMD_S_DONE;
                end
            end
            default: state_nxt = AMD_S_OPCODE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= AMD_S_OPCODE;
            o_q_ready <= 1'h0;
        end else begin
            state_r <= state_nxt;
            o_q_ready <= consumes(state_nxt);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            page2_r <= 1'h0;
            opc_r <= `AMD_ZERO8;
            mode_r <= AMD_NO_OPERAND_MODE;
            post_r <= `AMD_ZERO8;
        end else if (state_r == AMD_S_DONE) begin
            page2_r <= 1'h0;
        end else if (take && state_r == AMD_S_OPCODE) begin
            if (i_q_byte == `AMD_PAGE2_PREFIX && !page2_r) begin
                page2_r <= 1'h1;
            end else begin
                opc_r <= i_q_byte;
                mode_r <= i_q_mode;
            end
        end else if (take && state_r == AMD_S_POSTBYTE) begin
            post_r <= i_q_byte;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ext_r <= `AMD_ZERO16;
            ext_left_r <= `AMD_EXT_NONE;
        end else if (take && state_r == AMD_S_OPCODE) begin
            ext_r <= `AMD_ZERO16;
            ext_left_r <= mode_ext_cnt(i_q_mode);
        end else if (take && state_r == AMD_S_POSTBYTE) begin
            ext_left_r <= (mode_r == AMD_POSTBYTE_ONLY_MODE) ? `AMD_EXT_NONE : xb_ext_cnt;
        end else if (take && state_r == AMD_S_EXTENSION) begin
            ext_r <= {ext_r[7:0], i_q_byte};
            ext_left_r <= ext_left_r - `AMD_EXT_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_mem_req <= 1'h0;
            o_mem_addr <= `AMD_ZERO16;
            ptr_r <= `AMD_ZERO16;
        end else if (state_r == AMD_S_PTR_HI && !o_mem_req) begin
            o_mem_req <= 1'h1;
            o_mem_addr <= idx_sum;
        end else if (i_mem_ack && state_r == AMD_S_PTR_HI) begin
            ptr_r[15:8] <= i_mem_data;
            o_mem_addr <= o_mem_addr + `AMD_EXT_ONE;
        end else if (i_mem_ack && state_r == AMD_S_PTR_LO) begin
            ptr_r[7:0] <= i_mem_data;
            o_mem_req <= 1'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_done <= 1'h0;
            o_page2 <= 1'h0;
            o_opcode <= `AMD_ZERO8;
            o_mode <= AMD_NO_OPERAND_MODE;
            o_postbyte <= `AMD_ZERO8;
            o_idx_kind <= AMD_SHORT_INDEXED_MODE;
            o_ea <= `AMD_ZERO16;
            o_operand <= `AMD_ZERO16;
            o_upd_en <= 1'h0;
            o_upd_sel <= `AMD_BASE_X;
            o_upd_val <= `AMD_ZERO16;
        end else begin
            o_done <= (state_r == AMD_S_DONE);
            if (state_r == AMD_S_DONE) begin
                o_page2 <= page2_r;
                o_opcode <= opc_r;
                o_mode <= mode_r;
                o_postbyte <= post_r;
                o_idx_kind <= kind;
                o_ea <= ea_calc;
                o_operand <= (mode_r == AMD_LITERAL_OPERAND_MODE_B
                    || mode_r == AMD_LITERAL_OPERAND_MODE_W
                    || mode_r == AMD_POSTBYTE_ONLY_MODE) ? ext_r : `AMD_ZERO16;
                o_upd_en <= (mode_r == AMD_INDEXED_MODE) && (kind == AMD_AUTO_STEP_MODE);
                o_upd_sel <= base_sel;
                o_upd_val <= idx_sum;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_ptr_fetch;
        (state_r == AMD_S_PTR_LO && i_mem_ack) ##1 (state_r == AMD_S_DONE);
    endsequence

    property p_prefix_page;
        (state_r == AMD_S_OPCODE && take && i_q_byte == `AMD_PAGE2_PREFIX && !page2_r)
        |=> page2_r && state_r == AMD_S_OPCODE;
    endproperty
    a_prefix_page: assert property (p_prefix_page) else $error("prefix not paged");

    property p_no_operand;
        (state_r == AMD_S_OPCODE && take && i_q_byte != `AMD_PAGE2_PREFIX
            && i_q_mode == AMD_NO_OPERAND_MODE)
        |=> !o_q_ready && state_r == AMD_S_DONE ##1 o_done && o_ea == `AMD_ZERO16;
    endproperty
    a_no_operand: assert property (p_no_operand) else $error("no-operand took bytes");

    property p_direct_page;
        o_done && o_mode == AMD_DIRECT_PAGE_MODE |-> o_ea[15:8] == `AMD_DIRECT_PAGE_HI;
    endproperty
    a_direct_page: assert property (p_direct_page) else $error("direct left page");

    property p_full_address;
        o_done && o_mode == AMD_FULL_ADDRESS_MODE |-> o_ea == $past(ext_r);
    endproperty
    a_full_address: assert property (p_full_address) else $error("bad full address");

    property p_relative;
        o_done && o_mode == AMD_RELATIVE_MODE_B
        |-> o_ea == 16'($past(i_reg_pc) + sext8($past(ext_r[7:0])));
    endproperty
    a_relative: assert property (p_relative) else $error("bad relative target");

    property p_literal_byte;
        o_done && o_mode == AMD_LITERAL_OPERAND_MODE_B |-> o_operand[15:8] == `AMD_ZERO8;
    endproperty
    a_literal_byte: assert property (p_literal_byte) else $error("literal too wide");

    property p_high_first;
        (state_r == AMD_S_EXTENSION && take)
        |=> ext_r[7:0] == $past(i_q_byte) && ext_r[15:8] == $past(ext_r[7:0]);
    endproperty
    a_high_first: assert property (p_high_first) else $error("byte order wrong");

    property p_pointer_used;
        s_ptr_fetch |=> o_done && o_ea == ptr_r;
    endproperty
    a_pointer_used: assert property (p_pointer_used) else $error("pointer not used");

    property p_two_ext;
        (state_r == AMD_S_POSTBYTE && take && mode_r == AMD_INDEXED_MODE
            && xb_ext_cnt == `AMD_EXT_TWO)
        |=> state_r == AMD_S_EXTENSION && ext_left_r == `AMD_EXT_TWO;
    endproperty
    a_two_ext: assert property (p_two_ext) else $error("extension count wrong");

    property p_auto_update;
        o_done && o_idx_kind == AMD_AUTO_STEP_MODE && o_mode == AMD_INDEXED_MODE
        |-> o_upd_en && o_upd_sel != `AMD_BASE_PC;
    endproperty
    a_auto_update: assert property (p_auto_update) else $error("auto step lost");

endmodule

// *** verif/amd_mem_model.sv ***
`timescale 1ns/10ps

module amd_mem_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Pointer read request.
    input wire logic i_req,
    input wire logic [15:0] i_addr,
    input wire logic [3:0] i_lat,
    // Read answer.
    output logic o_ack,
    output logic [7:0] o_data
);
    logic [3:0] wait_r;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return {a[3:0], a[7:4]} ^ a[15:8] ^ 8'h5a;
    endfunction

    // Each read is answered after i_lat idle cycles; between answers the data lines toggle.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            o_data <= 8'h00;
            wait_r <= 4'h0;
        end else if (i_req && !o_ack && wait_r >= i_lat) begin
            o_ack <= 1'b1;
            o_data <= byte_at(i_addr);
            wait_r <= 4'h0;
        end else begin
            o_ack <= 1'b0;
            o_data <= ~o_data;
            wait_r <= (i_req && !o_ack) ? wait_r + 4'h1 : 4'h0;
        end
    end
endmodule

// *** verif/addressing_mode_decoder_test.sv ***
`timescale 1ns/10ps

module addressing_mode_decoder_test;
    import amd_pkg::*;
    logic i_clk, i_rst_n, i_q_valid, o_q_ready, o_mem_req, mem_ack, o_done, o_page2, o_upd_en;
    logic [7:0] i_q_byte, i_acc_a, i_acc_b, mem_data, o_opcode, o_postbyte;
    amd_mode_t i_q_mode, o_mode;
    amd_idx_t o_idx_kind;
    logic [15:0] i_reg_x, i_reg_y, i_reg_sp, i_reg_pc, o_mem_addr, o_ea, o_operand, o_upd_val;
    logic [15:0] seen0, seen1;
    logic [1:0] o_upd_sel;
    logic [3:0] lat;
    int fails, total_checks, cyc, acks;

    amd_decoder u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_q_valid(i_q_valid),
        .i_q_byte(i_q_byte), .i_q_mode(i_q_mode), .o_q_ready(o_q_ready), .i_reg_x(i_reg_x),
        .i_reg_y(i_reg_y), .i_reg_sp(i_reg_sp), .i_reg_pc(i_reg_pc), .i_acc_a(i_acc_a),
        .i_acc_b(i_acc_b), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(mem_ack),
        .i_mem_data(mem_data), .o_done(o_done), .o_page2(o_page2), .o_opcode(o_opcode),
        .o_mode(o_mode), .o_postbyte(o_postbyte), .o_idx_kind(o_idx_kind), .o_ea(o_ea),
        .o_operand(o_operand), .o_upd_en(o_upd_en), .o_upd_sel(o_upd_sel),
        .o_upd_val(o_upd_val));

    amd_mem_model u_mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_lat(lat), .o_ack(mem_ack), .o_data(mem_data));

    always #4 i_clk = ~i_clk;

    // Logs the address of every pointer byte handed over.
    always @(posedge i_clk) begin
        if (o_mem_req === 1'b1 && mem_ack === 1'b1) begin
            if (acks == 0) seen0 = o_mem_addr;
            else seen1 = o_mem_addr;
            acks++;
        end
    end

    function automatic logic [15:0] ptr(input logic [15:0] a);
        return {u_mem.byte_at(a), u_mem.byte_at(a + 16'h1)};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Offers n stream bytes, then counts cycles from the last taken byte to done.
    task automatic run(input int n, input logic [7:0] b0, b1, b2, b3, input amd_mode_t m);
        logic [7:0] bb [4];
        bb = '{b0, b1, b2, b3};
        @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            i_q_valid <= 1'b1;
            i_q_byte <= bb[i];
            i_q_mode <= m;
            do @(posedge i_clk); while (o_q_ready !== 1'b1);
        end
        i_q_valid <= 1'b0;
        cyc = 0;
        do begin
            @(posedge i_clk);
            #1;
            cyc++;
        end while (o_done !== 1'b1 && cyc < 40);
        chk("done", 16'h1, {15'h0, o_done});
    endtask

    task automatic plain(input logic [15:0] ea, input logic [15:0] opnd, input amd_mode_t m);
        chk("ea", ea, o_ea);
        chk("operand", opnd, o_operand);
        chk("mode", {12'h0, m}, {12'h0, o_mode});
        chk("latency", 16'h1, cyc[15:0]);
    endtask

    task automatic t_simple_modes;
        run(1, 8'h87, 8'h00, 8'h00, 8'h00, AMD_NO_OPERAND_MODE);
        plain(16'h0000, 16'h0000, AMD_NO_OPERAND_MODE);
        run(2, 8'h86, 8'hc3, 8'h00, 8'h00, AMD_LITERAL_OPERAND_MODE_B);
        plain(16'h0000, 16'h00c3, AMD_LITERAL_OPERAND_MODE_B);
        run(3, 8'hcc, 8'h12, 8'h34, 8'h00, AMD_LITERAL_OPERAND_MODE_W);
        plain(16'h0000, 16'h1234, AMD_LITERAL_OPERAND_MODE_W);
        run(2, 8'h96, 8'hff, 8'h00, 8'h00, AMD_DIRECT_PAGE_MODE);
        chk("direct ea", 16'h00ff, o_ea);
        run(3, 8'hb6, 8'hab, 8'hcd, 8'h00, AMD_FULL_ADDRESS_MODE);
        plain(16'habcd, 16'h0000, AMD_FULL_ADDRESS_MODE);
    endtask

    task automatic t_relative_page2;
        run(2, 8'h20, 8'hfe, 8'h00, 8'h00, AMD_RELATIVE_MODE_B);
        chk("rel8 ea", 16'h7ffe, o_ea);
        chk("page", 16'h0, {15'h0, o_page2});
        run(4, 8'h18, 8'h26, 8'h80, 8'h00, AMD_RELATIVE_MODE_W);
        chk("rel16 ea", 16'h0000, o_ea);
        chk("page", 16'h1, {15'h0, o_page2});
        chk("opcode", 16'h0026, {8'h0, o_opcode});
        run(2, 8'h18, 8'h18, 8'h00, 8'h00, AMD_NO_OPERAND_MODE);
        chk("page", 16'h1, {15'h0, o_page2});
        chk("opcode", 16'h0018, {8'h0, o_opcode});
    endtask

    task automatic idx_case(input logic [7:0] xb, input int n, input logic [7:0] e0, e1,
        input logic [15:0] ea, input amd_idx_t kind, input logic upd, input logic [15:0] uval);
        run(2 + n, 8'ha6, xb, e0, e1, AMD_INDEXED_MODE);
        chk("idx ea", ea, o_ea);
        chk("idx kind", {13'h0, kind}, {13'h0, o_idx_kind});
        chk("postbyte", {8'h0, xb}, {8'h0, o_postbyte});
        chk("upd en", {15'h0, upd}, {15'h0, o_upd_en});
        if (upd) begin
            chk("upd val", uval, o_upd_val);
            chk("upd sel", {14'h0, xb[7:6]}, {14'h0, o_upd_sel});
        end
        if (kind != AMD_OFFSET_INDIRECT_MODE && kind != AMD_DOUBLE_ACC_INDIRECT_MODE)
            chk("latency", 16'h1, cyc[15:0]);
    endtask

    task automatic t_indexed;
        idx_case(8'h1f, 0, 8'h00, 8'h00, 16'h0fff, AMD_SHORT_INDEXED_MODE, 0, 0);
        idx_case(8'h50, 0, 8'h00, 8'h00, 16'h2fe0, AMD_SHORT_INDEXED_MODE, 0, 0);
        idx_case(8'hcf, 0, 8'h00, 8'h00, 16'h800f, AMD_SHORT_INDEXED_MODE, 0, 0);
        idx_case(8'h8f, 0, 8'h00, 8'h00, 16'h000d, AMD_SHORT_INDEXED_MODE, 0, 0);
        idx_case(8'he1, 1, 8'h00, 8'h00, 16'h0f00, AMD_NINE_BIT_INDEXED_MODE, 0, 0);
        idx_case(8'hf0, 1, 8'hff, 8'h00, 16'h00fd, AMD_NINE_BIT_INDEXED_MODE, 0, 0);
        idx_case(8'hea, 2, 8'h12, 8'h34, 16'h4224, AMD_SIXTEEN_BIT_INDEXED_MODE, 0, 0);
        idx_case(8'he4, 0, 8'h00, 8'h00, 16'h1080, AMD_ACC_OFFSET_MODE, 0, 0);
        idx_case(8'hed, 0, 8'h00, 8'h00, 16'h306f, AMD_ACC_OFFSET_MODE, 0, 0);
        idx_case(8'hfe, 0, 8'h00, 8'h00, 16'h007f, AMD_ACC_OFFSET_MODE, 0, 0);
        idx_case(8'h20, 0, 8'h00, 8'h00, 16'h1001, AMD_AUTO_STEP_MODE, 1, 16'h1001);
        idx_case(8'h78, 0, 8'h00, 8'h00, 16'h2ff0, AMD_AUTO_STEP_MODE, 1, 16'h2fe8);
        idx_case(8'ha7, 0, 8'h00, 8'h00, 16'h0006, AMD_AUTO_STEP_MODE, 1, 16'h0006);
    endtask

    task automatic t_indirect;
        lat = 4'h3;
        acks = 0;
        idx_case(8'he3, 2, 8'h00, 8'h10, ptr(16'h1010), AMD_OFFSET_INDIRECT_MODE, 0, 0);
        chk("ptr reads", 16'h2, acks[15:0]);
        chk("ptr hi addr", 16'h1010, seen0);
        chk("ptr lo addr", 16'h1011, seen1);
        lat = 4'h0;
        acks = 0;
        idx_case(8'hf7, 0, 8'h00, 8'h00, ptr(16'h807d), AMD_DOUBLE_ACC_INDIRECT_MODE, 0, 0);
        chk("ptr reads", 16'h2, acks[15:0]);
        chk("ptr hi addr", 16'h807d, seen0);
        chk("ptr lo addr", 16'h807e, seen1);
    endtask

    task automatic t_postbyte_only;
        run(2, 8'hb7, 8'h10, 8'h00, 8'h00, AMD_POSTBYTE_ONLY_MODE);
        plain(16'h0000, 16'h0000, AMD_POSTBYTE_ONLY_MODE);
        chk("postbyte", 16'h0010, {8'h0, o_postbyte});
        run(2, 8'h04, 8'h20, 8'h00, 8'h00, AMD_POSTBYTE_ONLY_MODE);
        chk("postbyte", 16'h0020, {8'h0, o_postbyte});
    endtask

    // A reset in mid-instruction must drop the half-decoded opcode.
    task automatic t_reset_midway;
        @(posedge i_clk);
        i_q_valid <= 1'b1;
        i_q_byte <= 8'hb6;
        i_q_mode <= AMD_FULL_ADDRESS_MODE;
        do @(posedge i_clk); while (o_q_ready !== 1'b1);
        i_q_valid <= 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        chk("ready in reset", 16'h0, {15'h0, o_q_ready});
        chk("ea in reset", 16'h0, o_ea);
        chk("mode in reset", 16'h0, {12'h0, o_mode});
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        run(1, 8'h87, 8'h00, 8'h00, 8'h00, AMD_NO_OPERAND_MODE);
        plain(16'h0000, 16'h0000, AMD_NO_OPERAND_MODE);
    endtask

    initial begin
        #100000;
        fails++;
        report_and_stop;
    end

    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_q_valid = 1'b0;
        i_q_byte = 8'h00;
        i_q_mode = AMD_NO_OPERAND_MODE;
        i_reg_x = 16'h1000;
        i_reg_y = 16'h2ff0;
        i_reg_sp = 16'hfffe;
        i_reg_pc = 16'h8000;
        i_acc_a = 8'h80;
        i_acc_b = 8'h7f;
        lat = 4'h0;
        fails = 0;
        total_checks = 0;
        acks = 0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_simple_modes;
        t_relative_page2;
        t_indexed;
        t_indirect;
        t_postbyte_only;
        t_reset_midway;
        report_and_stop;
    end
endmodule
